// file: hdl/am_station.sv
/*
 * Auto/manual output station for one loop: picks the loop output from the
 * automatic input, the safety value or the manual register.
 * Assumes inputs synchronous to I_CLK; keys arrive as one-cycle pulses;
 * the last mode is held by an always-on supply outside (I_LAST_MODE).
 */
// Function
// [R1] Safety input high: safety switch at 1, output follows safety value.
// [R2] Safety entered in manual: indicator lit, output frozen safety sample.
// [R3] Safety in auto: live safety value out, indicator flashes fast.
// [R4] Safety release moves mode switch: keep, manual or auto per setting.
// [R5] Source setting: key, lock auto, lock manual, key or inputs.
// [R6] Permitted override inputs move the mode switch while high.
// [R7] Override forces manual if position setting 0, auto if 1.
// [R8] Forced manual release restores the mode switch held before it.
// [R9] Forced manual: position 0 flashes slowly, position 1 lit steadily; code lights position 0 steadily and flashes position 1 slowly.
// [R10] Mode key ignored while its lock applies.
// [R11] Raise and lower keys ignored while their lock applies.
// [R12] After power loss, start in mode picked by restart setting.
// [R13] Limiter on in both modes by default, auto only if selected.
// [R14] Forced manual entry loads register with the automatic path value.
// [R15] Key lock codes: none, forced manual, safety, either.
// [R16] Restart codes: last mode, manual, auto.
// [R17] Limiter scope codes: both modes, auto only.
// [R18] Both overrides high: forced manual wins, register out, slow flash; code lights the indicator steadily while the mode switch is in manual.
// [R19] Fast and slow flash from clock dividers, fast quicker than slow.
`timescale 1ns/1ps
module am_station #(
    parameter int DATA_W   = am_station_pkg::DATA_W,
    parameter int FAST_CYC = am_station_pkg::FAST_HALF_CYC,
    parameter int SLOW_CYC = am_station_pkg::SLOW_HALF_CYC,
    parameter logic [DATA_W-1:0] STEP = DATA_W'(1)
) (
    // Clock and reset
    input  wire logic                 I_CLK,
    input  wire logic                 I_NRST,
    // Analog inputs
    input  wire logic [DATA_W-1:0]    I_AUTO_INPUT_LINK,
    input  wire logic [DATA_W-1:0]    I_SAFETY_VALUE_LINK,
    // Discrete overrides
    input  wire logic                 I_SAFETY_TRIGGER_LINK,
    input  wire logic                 I_FORCED_MANUAL_LINK,
    // Front panel and settings
    input  wire am_station_pkg::keys_t I_KEYS,
    input  wire am_station_pkg::cfg_t  I_CFG,
    input  wire logic                 I_LAST_MODE,
    // Output limits
    input  wire logic [DATA_W-1:0]    I_LIMIT_LOW,
    input  wire logic [DATA_W-1:0]    I_LIMIT_HIGH,
    // Results
    output logic [DATA_W-1:0]         O_OUTPUT,
    output logic                      O_MANUAL_LED,
    output logic                      O_MODE_SWITCH,
    output logic                      O_SAFETY_SWITCH,
    output logic                      O_FORCED_MANUAL_SWITCH
);

    typedef struct packed {
        logic              started;
        logic              mode_switch;
        logic              safety_switch;
        logic              forced_manual_switch;
        logic              saved_mode;
        logic              safety_frozen;
        logic [DATA_W-1:0] safety_hold;
        logic [DATA_W-1:0] manual_reg;
        logic [DATA_W-1:0] out;
        logic              led;
    } st_t;

    st_t  st_reg;
    st_t  st_next;
    logic fast_wave;
    logic slow_wave;

    // Two dividers, fast period shorter than slow
    flash_divider #(.HALF_CYC(FAST_CYC)) u_fast ( // [R19]
        .i_clk  (I_CLK),
        .i_nrst (I_NRST),
        .o_wave (fast_wave)
    );
    flash_divider #(.HALF_CYC(SLOW_CYC)) u_slow ( // [R19]
        .i_clk  (I_CLK),
        .i_nrst (I_NRST),
        .o_wave (slow_wave)
    );

    // Decode of settings
    logic src_fm;
    logic src_safe;
    logic ovr_pos;
    logic am_locked;
    logic rl_locked;
    logic fm_rise;
    logic fm_fall;
    logic sf_rise;
    logic sf_fall;

    always_comb begin
        src_fm   = (I_CFG.mode_switch_source == am_station_pkg::SRC_KEY_FM) ||
                   (I_CFG.mode_switch_source == am_station_pkg::SRC_KEY_BOTH); // [R5]
        src_safe = (I_CFG.mode_switch_source == am_station_pkg::SRC_KEY_SAFE) ||
                   (I_CFG.mode_switch_source == am_station_pkg::SRC_KEY_BOTH); // [R5]
        ovr_pos  = (I_CFG.override_position_sel == am_station_pkg::OVR_TO_MANUAL)
                   ? am_station_pkg::POS_MANUAL : am_station_pkg::POS_AUTO; // [R7]
        am_locked = (I_CFG.mode_key_lock[am_station_pkg::LOCK_FM_BIT] && I_FORCED_MANUAL_LINK) ||
                    (I_CFG.mode_key_lock[am_station_pkg::LOCK_SAFE_BIT] &&
                     I_SAFETY_TRIGGER_LINK); // [R10] [R15]
        rl_locked = (I_CFG.raise_lower_key_lock[am_station_pkg::LOCK_FM_BIT] &&
                     I_FORCED_MANUAL_LINK) ||
                    (I_CFG.raise_lower_key_lock[am_station_pkg::LOCK_SAFE_BIT] &&
                     I_SAFETY_TRIGGER_LINK); // [R11] [R15]
        fm_rise = I_FORCED_MANUAL_LINK && !st_reg.forced_manual_switch;
        fm_fall = !I_FORCED_MANUAL_LINK && st_reg.forced_manual_switch;
        sf_rise = I_SAFETY_TRIGGER_LINK && !st_reg.safety_switch;
        sf_fall = !I_SAFETY_TRIGGER_LINK && st_reg.safety_switch;
    end

    // Next-state logic for switches, register and output
    logic              mode_n;
    logic              manual_path;
    logic [DATA_W-1:0] sel;
    logic [DATA_W-1:0] lim;
    logic              limit_on;

    always_comb begin
        st_next = st_reg;
        mode_n  = st_reg.mode_switch;
        sel     = '0;
        lim     = '0;
        limit_on = 1'b0;
        manual_path = 1'b0;
        st_next.forced_manual_switch = I_FORCED_MANUAL_LINK;
        st_next.safety_switch        = I_SAFETY_TRIGGER_LINK; // [R1]

        if (!st_reg.started) begin
            // First cycle after reset picks the restart mode
            st_next.started = 1'b1;
            unique case (I_CFG.restart_mode_sel) // [R12] [R16]
                am_station_pkg::RST_MANUAL: mode_n = am_station_pkg::POS_MANUAL;
                am_station_pkg::RST_AUTO:   mode_n = am_station_pkg::POS_AUTO;
                default:                    mode_n = I_LAST_MODE;
            endcase
            st_next.manual_reg = I_AUTO_INPUT_LINK;
        end else begin
            // Front key, unless locked
            if (I_KEYS.am_key && !am_locked) begin // [R10]
                mode_n = ~st_reg.mode_switch;
            end
            // Remember position held before forced manual
            if (fm_rise) begin
                st_next.saved_mode = st_reg.mode_switch;
            end
            // Override inputs drive the switch while high
            if ((src_fm && I_FORCED_MANUAL_LINK && fm_rise) ||
                (src_safe && I_SAFETY_TRIGGER_LINK && sf_rise)) begin // [R6]
                mode_n = ovr_pos; // [R7]
            end
            if ((src_fm && I_FORCED_MANUAL_LINK) ||
                (src_safe && I_SAFETY_TRIGGER_LINK)) begin // [R6]
                if (am_locked || !I_KEYS.am_key) begin
                    mode_n = ovr_pos; // [R7]
                end
            end
            // Safety release places the switch
            if (sf_fall) begin
                unique case (I_CFG.safety_release_position) // [R4]
                    am_station_pkg::REL_MANUAL: mode_n = am_station_pkg::POS_MANUAL;
                    am_station_pkg::REL_AUTO:   mode_n = am_station_pkg::POS_AUTO;
                    default:                    mode_n = mode_n;
                endcase
            end
            // Forced manual release restores the earlier position
            if (fm_fall) begin
                mode_n = st_reg.saved_mode; // [R8]
            end
            // Hold value when safety begins in manual
            if (sf_rise) begin
                st_next.safety_hold   = I_SAFETY_VALUE_LINK; // [R2]
                st_next.safety_frozen = (mode_n == am_station_pkg::POS_MANUAL); // [R2]
            end else if (!I_SAFETY_TRIGGER_LINK) begin
                st_next.safety_frozen = 1'b0;
            end
            // Tracking and key actuation of the manual register
            manual_path = st_reg.mode_switch || st_reg.forced_manual_switch;
            if (fm_rise) begin
                st_next.manual_reg = I_AUTO_INPUT_LINK; // [R14]
            end else if (!manual_path) begin
                st_next.manual_reg = I_AUTO_INPUT_LINK;
            end else if (!rl_locked) begin // [R11]
                if (I_KEYS.raise_key && !I_KEYS.lower_key &&
                    st_reg.manual_reg <= ~STEP) begin
                    st_next.manual_reg = st_reg.manual_reg + STEP;
                end else if (I_KEYS.lower_key && !I_KEYS.raise_key &&
                             st_reg.manual_reg >= STEP) begin
                    st_next.manual_reg = st_reg.manual_reg - STEP;
                end
            end
        end
        // Source locks pin the switch last, so no key, override or restart escapes them
        if (I_CFG.mode_switch_source == am_station_pkg::SRC_LOCK_AUTO) begin
            mode_n = am_station_pkg::POS_AUTO; // [R5]
        end else if (I_CFG.mode_switch_source == am_station_pkg::SRC_LOCK_MAN) begin
            mode_n = am_station_pkg::POS_MANUAL; // [R5]
        end
        st_next.mode_switch = mode_n;

        // Output selection; forced manual takes precedence
        manual_path = st_reg.mode_switch || st_reg.forced_manual_switch;
        if (st_reg.forced_manual_switch) begin
            sel = st_reg.manual_reg; // [R18]
        end else if (st_reg.safety_switch) begin
            sel = st_reg.safety_frozen ? st_reg.safety_hold // [R2]
                                       : I_SAFETY_VALUE_LINK; // [R1] [R3]
        end else if (st_reg.mode_switch) begin
            sel = st_reg.manual_reg;
        end else begin
            sel = I_AUTO_INPUT_LINK;
        end

        // Limiter scope
        limit_on = !(manual_path &&
                     I_CFG.limiter_scope_sel == am_station_pkg::LIM_AUTO_ONLY); // [R13] [R17]
        lim = sel;
        if (limit_on && sel > I_LIMIT_HIGH) begin
            lim = I_LIMIT_HIGH; // [R13]
        end else if (limit_on && sel < I_LIMIT_LOW) begin
            lim = I_LIMIT_LOW; // [R13]
        end
        st_next.out = lim;

        // Indicator
        if (st_reg.mode_switch) begin
            st_next.led = 1'b1; // [R2] [R9]
        end else if (st_reg.forced_manual_switch) begin
            st_next.led = slow_wave; // [R9] [R18]
        end else if (st_reg.safety_switch) begin
            st_next.led = fast_wave; // [R3]
        end else begin
            st_next.led = 1'b0;
        end
    end

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from state
    assign O_OUTPUT               = st_reg.out;
    assign O_MANUAL_LED           = st_reg.led;
    assign O_MODE_SWITCH          = st_reg.mode_switch;
    assign O_SAFETY_SWITCH        = st_reg.safety_switch;
    assign O_FORCED_MANUAL_SWITCH = st_reg.forced_manual_switch;

endmodule // am_station

// file: hdl/am_station_pkg.sv
/*
 * Constants and carrier types for the auto/manual output station.
 * Assumes one 200 MHz clock; all inputs synchronous to it.
 */
package am_station_pkg;

    localparam int DATA_W = 16;

    // Clock and flash timing
    localparam int  CLK_MHZ       = 200;
    localparam int  FAST_FLASH_MS = 125;
    localparam int  SLOW_FLASH_MS = 500;
    localparam int  FAST_HALF_CYC = FAST_FLASH_MS * 1000 * CLK_MHZ;
    localparam int  SLOW_HALF_CYC = SLOW_FLASH_MS * 1000 * CLK_MHZ;

    // Mode switch positions
    localparam logic POS_AUTO   = 1'b0;
    localparam logic POS_MANUAL = 1'b1;

    // Mode switch source setting
    localparam logic [2:0] SRC_KEY       = 3'h0;
    localparam logic [2:0] SRC_LOCK_AUTO = 3'h1;
    localparam logic [2:0] SRC_LOCK_MAN  = 3'h2;
    localparam logic [2:0] SRC_KEY_FM    = 3'h3;
    localparam logic [2:0] SRC_KEY_SAFE  = 3'h4;
    localparam logic [2:0] SRC_KEY_BOTH  = 3'h5;

    // Override position setting
    localparam logic OVR_TO_MANUAL = 1'b0;

    // Safety release setting
    localparam logic [1:0] REL_LAST   = 2'h0;
    localparam logic [1:0] REL_MANUAL = 2'h1;
    localparam logic [1:0] REL_AUTO   = 2'h2;

    // Key lock setting bits: bit0 forced manual, bit1 safety
    localparam int LOCK_FM_BIT   = 0;
    localparam int LOCK_SAFE_BIT = 1;

    // Restart setting
    localparam logic [1:0] RST_LAST   = 2'h0;
    localparam logic [1:0] RST_MANUAL = 2'h1;
    localparam logic [1:0] RST_AUTO   = 2'h2;

    // Limiter scope setting
    localparam logic LIM_AUTO_ONLY = 1'b1;

    // Configuration carrier
    typedef struct packed {
        logic [2:0] mode_switch_source;
        logic       override_position_sel;
        logic [1:0] safety_release_position;
        logic [1:0] mode_key_lock;
        logic [1:0] raise_lower_key_lock;
        logic [1:0] restart_mode_sel;
        logic       limiter_scope_sel;
    } cfg_t;

    // Front panel key carrier, one-cycle pulses
    typedef struct packed {
        logic am_key;
        logic raise_key;
        logic lower_key;
    } keys_t;

endpackage

// file: hdl/flash_divider.sv
/*
 * Square-wave divider for indicator flashing.
 * Assumes a free-running clock; toggles every HALF_CYC cycles.
 */
`timescale 1ns/1ps
module flash_divider #(
    parameter int HALF_CYC = 2
) (
    input  wire logic i_clk,
    input  wire logic i_nrst,
    output logic      o_wave
);
    localparam int CW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          wave;
    } div_state_t;

    div_state_t st_reg;
    div_state_t st_next;

    // Count to half period, then flip
    always_comb begin
        st_next = st_reg;
        if (st_reg.cnt == CW'(HALF_CYC - 1)) begin
            st_next.cnt  = '0;
            st_next.wave = ~st_reg.wave;
        end else begin
            st_next.cnt = st_reg.cnt + CW'(1);
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_wave = st_reg.wave;
endmodule // flash_divider

// file: tb/am_station_assertions.sv
/* Port checker for the auto/manual station.
   Assumes it is bound to am_station and that limits stay steady. */
`timescale 1ns/1ps
module am_station_assertions #(
    parameter int DATA_W   = 16,
    parameter int FAST_CYC = 4,
    parameter int SLOW_CYC = 16
) (
    // Clock and reset
    input wire logic                  I_CLK,
    input wire logic                  I_NRST,
    // Station inputs
    input wire logic [DATA_W-1:0]     I_AUTO_INPUT_LINK,
    input wire logic [DATA_W-1:0]     I_SAFETY_VALUE_LINK,
    input wire logic                  I_SAFETY_TRIGGER_LINK,
    input wire logic                  I_FORCED_MANUAL_LINK,
    input wire am_station_pkg::keys_t I_KEYS,
    input wire am_station_pkg::cfg_t  I_CFG,
    input wire logic [DATA_W-1:0]     I_LIMIT_LOW,
    input wire logic [DATA_W-1:0]     I_LIMIT_HIGH,
    // Station outputs
    input wire logic [DATA_W-1:0]     O_OUTPUT,
    input wire logic                  O_MANUAL_LED,
    input wire logic                  O_MODE_SWITCH,
    input wire logic                  O_SAFETY_SWITCH,
    input wire logic                  O_FORCED_MANUAL_SWITCH
);
    logic [DATA_W-1:0] auto_lim, safe_lim;
    logic [7:0]        run_cnt;
    logic [1:0]        kind, kind_q;
    logic              led_q, ovr, lk, calm;
    logic [2:0]        src;

    function automatic logic [DATA_W-1:0] lim(input logic [DATA_W-1:0] v, lo, hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // Limited paths, override and lock conditions
    assign auto_lim = lim(I_AUTO_INPUT_LINK, I_LIMIT_LOW, I_LIMIT_HIGH);
    assign safe_lim = lim(I_SAFETY_VALUE_LINK, I_LIMIT_LOW, I_LIMIT_HIGH);
    assign src      = I_CFG.mode_switch_source;
    assign ovr      = (src == 3'h3 && I_FORCED_MANUAL_LINK) || (src == 3'h4 && I_SAFETY_TRIGGER_LINK)
                      || (src == 3'h5 && (I_FORCED_MANUAL_LINK || I_SAFETY_TRIGGER_LINK));
    assign lk       = (I_CFG.mode_key_lock[0] && I_FORCED_MANUAL_LINK && O_FORCED_MANUAL_SWITCH)
                      || (I_CFG.mode_key_lock[1] && I_SAFETY_TRIGGER_LINK && O_SAFETY_SWITCH);
    // Releases also move the mode switch, so key checks skip them
    assign calm     = (O_SAFETY_SWITCH == I_SAFETY_TRIGGER_LINK)
                      && !(O_FORCED_MANUAL_SWITCH && !I_FORCED_MANUAL_LINK);
    assign kind     = {O_SAFETY_SWITCH & ~O_MODE_SWITCH & ~O_FORCED_MANUAL_SWITCH,
                       O_FORCED_MANUAL_SWITCH & ~O_MODE_SWITCH};

    // Length of the current steady run of the indicator, per flash kind
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            run_cnt <= 8'h00;
            led_q   <= 1'b0;
            kind_q  <= 2'h0;
        end else begin
            led_q   <= O_MANUAL_LED;
            kind_q  <= kind;
            run_cnt <= (O_MANUAL_LED == led_q && kind == kind_q) ? run_cnt + 8'h01 : 8'h00;
        end
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_NRST);

    a_safety_follow: assert property (I_SAFETY_TRIGGER_LINK |=> O_SAFETY_SWITCH)
        else $error("safety switch did not follow its input");
    a_forced_follow: assert property (I_FORCED_MANUAL_LINK |=> O_FORCED_MANUAL_SWITCH)
        else $error("forced manual switch did not follow its input");
    a_lock_auto: assert property ((src == 3'h1) [*3] |-> !O_MODE_SWITCH)
        else $error("mode switch left auto while locked there");
    a_lock_manual: assert property ((src == 3'h2) [*3] |-> O_MODE_SWITCH)
        else $error("mode switch left manual while locked there");
    a_override_pos: assert property (ovr && calm
        |=> O_MODE_SWITCH == !$past(I_CFG.override_position_sel))
        else $error("override did not place the mode switch");
    a_key_action: assert property (src == 3'h0 && I_KEYS.am_key && calm
        |=> O_MODE_SWITCH == ($past(O_MODE_SWITCH) ^ !$past(lk)))
        else $error("mode key action wrong for its lock");
    a_manual_lit: assert property (O_MODE_SWITCH [*2] |-> O_MANUAL_LED)
        else $error("indicator not lit in manual");
    a_auto_unlit: assert property ((!O_MODE_SWITCH && !O_SAFETY_SWITCH
        && !O_FORCED_MANUAL_SWITCH) [*2] |-> !O_MANUAL_LED)
        else $error("indicator lit in plain auto");
    a_auto_out: assert property ((!O_MODE_SWITCH && !O_SAFETY_SWITCH
        && !O_FORCED_MANUAL_SWITCH) [*3] ##0 $stable(auto_lim) |-> O_OUTPUT == auto_lim)
        else $error("auto output not the limited auto input");
    a_safety_live: assert property (kind[1] [*3] ##0 $stable(safe_lim)
        |-> O_OUTPUT == safe_lim)
        else $error("safety output not the live safety value");
    a_fast_flash: assert property (kind[1] |-> run_cnt <= FAST_CYC + 1)
        else $error("fast flash too slow");
    a_slow_flash: assert property (kind[0] |-> run_cnt <= SLOW_CYC + 1)
        else $error("slow flash too slow");
endmodule // am_station_assertions

bind am_station am_station_assertions #(.DATA_W(DATA_W), .FAST_CYC(FAST_CYC),
    .SLOW_CYC(SLOW_CYC)) u_chk (.*);

// file: tb/panel_model.sv
/* Front panel model: turns held key requests into one-cycle pulses.
   Assumes each request is held for at least one clock. */
`timescale 1ns/1ps
module panel_model (
    // Clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_nrst,
    // Held requests and pulses
    input  wire am_station_pkg::keys_t i_req,
    output am_station_pkg::keys_t      o_keys
);
    am_station_pkg::keys_t req_q;

    // One pulse per press, as a debounced key edge
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            req_q  <= '0;
            o_keys <= '0;
        end else begin
            req_q  <= i_req;
            o_keys <= i_req & ~req_q;
        end
    end
endmodule // panel_model

// file: tb/auto_manual_override_station_test.sv
/* Self-checking bench for the auto/manual station.
   Assumes the checker binds itself to the station. */
`timescale 1ns/1ps
module auto_manual_override_station_test;
    localparam int FC = 4;
    localparam int SC = 16;
    logic                  clk = 1'b0;
    logic                  nrst, st, fm, lm, led, mode, sws, swf, tog;
    logic [15:0]           ain, sv, lo, hi, out, a;
    am_station_pkg::keys_t req, keys;
    am_station_pkg::cfg_t  cfg;
    int                    n_mismatch = 0;
    int                    cmp_count = 0;

    am_station #(.FAST_CYC(FC), .SLOW_CYC(SC)) u_dut (.I_CLK(clk), .I_NRST(nrst),
        .I_AUTO_INPUT_LINK(ain), .I_SAFETY_VALUE_LINK(sv), .I_SAFETY_TRIGGER_LINK(st),
        .I_FORCED_MANUAL_LINK(fm), .I_KEYS(keys), .I_CFG(cfg), .I_LAST_MODE(lm),
        .I_LIMIT_LOW(lo), .I_LIMIT_HIGH(hi), .O_OUTPUT(out), .O_MANUAL_LED(led),
        .O_MODE_SWITCH(mode), .O_SAFETY_SWITCH(sws), .O_FORCED_MANUAL_SWITCH(swf));
    panel_model u_panel (.i_clk(clk), .i_nrst(nrst), .i_req(req), .o_keys(keys));

    // 200 MHz clock
    always #2.5 clk = ~clk;

    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic restart_exp(input logic [1:0] rs, input logic l);
        return (rs == 2'h0) ? l : (rs == 2'h1);
    endfunction

    // Inputs move 1 ns after the edge, clear of sampling
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic press(input logic [2:0] k);
        req = am_station_pkg::keys_t'(k);
        step(1);
        req = '0;
        step(3);
    endtask
    task automatic rst(input logic [1:0] rs, input logic l);
        nrst = 1'b0;
        cfg = '0;
        cfg.restart_mode_sel = rs;
        lm = l;
        st = 1'b0;
        fm = 1'b0;
        step(2);
        nrst = 1'b1;
        step(3);
    endtask
    // Flash phase is free running, so watch for any toggle
    task automatic flash(input int n);
        logic l0;
        l0 = led;
        tog = 1'b0;
        repeat (n) begin
            step(1);
            if (led !== l0) tog = 1'b1;
        end
    endtask
    task automatic stop_test();
        if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Hang guard, well beyond the expected run
    initial begin
        #100000;
        n_mismatch++;
        stop_test();
    end

    initial begin
        {nrst, st, fm, lm, req, cfg, ain, sv, lo} = '0;
        hi = 16'hFFFF;
        a = 16'h0044;
        step(6);
        for (int i = 0; i < 4; i++) begin
            rst((i < 2) ? 2'h0 : 2'(i - 1), i[0]);
            chk("restart", 16'(restart_exp(cfg.restart_mode_sel, lm)), 16'(mode));
        end
        cfg.mode_switch_source = 3'h1;
        step(4);
        chk("lock_auto", 16'h0, 16'(mode));
        cfg.mode_switch_source = 3'h2;
        step(4);
        chk("lock_man", 16'h1, 16'(mode));
        cfg.mode_switch_source = 3'h1;
        step(4);
        chk("lock_auto_back", 16'h0, 16'(mode));
        // Keys, register and raise/lower lock codes
        rst(2'h2, 1'b0);
        a = lfsr(a);
        ain = a & 16'h7FFF;
        step(3);
        press(3'h4);
        chk("key_mode", 16'h1, 16'(mode));
        chk("balanceless", ain, out);
        press(3'h2);
        chk("raise", ain + 16'h1, out);
        press(3'h1);
        chk("lower", ain, out);
        cfg.raise_lower_key_lock = 2'h1;
        fm = 1'b1;
        step(3);
        press(3'h2);
        chk("raise_lock", ain, out);
        cfg.raise_lower_key_lock = 2'h2;
        press(3'h2);
        chk("raise_free", ain + 16'h1, out);
        // Forced manual with both override positions
        rst(2'h2, 1'b0);
        cfg.mode_switch_source = 3'h3;
        a = lfsr(a);
        ain = a;
        step(3);
        fm = 1'b1;
        step(1);
        ain = ~a;
        step(3);
        chk("fm_mode", 16'h1, 16'(mode));
        chk("fm_out", a, out);
        chk("fm_led", 16'h1, 16'(led));
        chk("fm_sw", 16'h1, 16'(swf));
        fm = 1'b0;
        step(3);
        chk("fm_restore", 16'h0, 16'(mode));
        cfg.override_position_sel = 1'b1;
        fm = 1'b1;
        step(3);
        chk("fm_auto", 16'h0, 16'(mode));
        chk("fm_load", ~a, out);
        flash(2 * SC + 4);
        chk("slow_flash", 16'h1, 16'(tog));
        sv = a;
        st = 1'b1;
        step(3);
        chk("both_out", ~a, out);
        // Safety in auto, live value, fast flash; safety in manual, frozen value; release, source and key lock codes
        rst(2'h2, 1'b0);
        a = lfsr(a);
        sv = a;
        st = 1'b1;
        step(3);
        chk("safe_sw", 16'h1, 16'(sws));
        chk("safe_out", a, out);
        flash(2 * FC + 4);
        chk("fast_flash", 16'h1, 16'(tog));
        sv = ~a;
        step(2);
        chk("safe_live", ~a, out);
        st = 1'b0;
        step(3);
        press(3'h4);
        sv = a;
        st = 1'b1;
        step(2);
        sv = ~a;
        step(3);
        chk("safe_frozen", a, out);
        chk("safe_led", 16'h1, 16'(led));
        for (int r = 0; r < 3; r++) begin
            rst(2'h2, 1'b0);
            cfg.safety_release_position = 2'(r);
            st = 1'b1;
            step(3);
            st = 1'b0;
            step(3);
            chk("release", 16'(r == 1), 16'(mode));
        end
        for (int s = 3; s < 6; s++) begin
            rst(2'h2, 1'b0);
            cfg.mode_switch_source = 3'(s);
            st = 1'b1;
            step(3);
            chk("src_safe", 16'(s != 3), 16'(mode));
        end
        for (int c = 0; c < 8; c++) begin
            rst(2'h2, 1'b0);
            cfg.mode_key_lock = 2'(c >> 1);
            st = c[0];
            fm = !c[0];
            step(3);
            press(3'h4);
            chk("key_lock", 16'(!cfg.mode_key_lock[c[0]]), 16'(mode));
        end
        // Limiter scope, corner limits
        rst(2'h2, 1'b0);
        lo = 16'h0100;
        hi = 16'h0200;
        ain = 16'h0050;
        step(3);
        chk("lim_low", 16'h0100, out);
        ain = 16'h0300;
        step(3);
        chk("lim_high", 16'h0200, out);
        press(3'h4);
        chk("lim_man", 16'h0200, out);
        cfg.limiter_scope_sel = 1'b1;
        step(3);
        chk("lim_auto_only", 16'h0300, out);
        stop_test();
    end
endmodule // auto_manual_override_station_test
